// File: logic/smw_link_if.sv
/*
  Two-wire link between the SMBus master end and the target end.
  Assumes pull-ups: a line is high unless an end enables its low drive.
*/
`timescale 1ns/1ps
`default_nettype none

interface smw_link_if;
  logic m_scl_o;
  logic m_scl_oe_n;
  logic m_sda_o;
  logic m_sda_oe_n;
  logic t_sda_o;
  logic t_sda_oe_n;
  logic scl;
  logic sda;

  // Wired-AND resolution of the open-drain lines
  assign scl = m_scl_oe_n | m_scl_o;
  assign sda = (m_sda_oe_n | m_sda_o) & (t_sda_oe_n | t_sda_o);

  modport master (output m_scl_o, m_scl_oe_n, m_sda_o, m_sda_oe_n, input scl, sda);
  modport target (output t_sda_o, t_sda_oe_n, input scl, sda);
endinterface

`default_nettype wire

// File: logic/smw_map.svh
/*
  Constants of the SMBus word target and its master: slave address, identity
  command codes and values, link timing counts.
  Assumes inclusion by bare name from the files of this block only.
*/
`ifndef SMW_MAP_SVH
`define SMW_MAP_SVH

// ****************************************************************
// Addressing and identity
// ****************************************************************
`define SMW_SLAVE_ADDR 7'h09
`define SMW_CMD_MAKER  8'hfe
`define SMW_CMD_PART   8'hff
// Arbitrary identity values, not taken from any real part
`define SMW_MAKER_ID   16'h005a
`define SMW_PART_ID    16'h0123

// ****************************************************************
// Timing
// ****************************************************************
`define SMW_CLK_NS     4
`define SMW_SCL_NS     400
`define SMW_QTR_CYC    (`SMW_SCL_NS / (4 * `SMW_CLK_NS))
`define SMW_QTR_W      6

`endif

// File: logic/smw_master.sv
/*
  SMBus master end: issues one word write or word read per request,
  generating SCL from core_clk by a divider.
  Assumes a target that never stretches SCL.
*/
`timescale 1ns/1ps
`default_nettype none
`include "smw_map.svh"

module smw_master (
  input  wire logic        core_clk,   // 250 MHz clock
  input  wire logic        sys_rst,    // Synchronous reset, high
  smw_link_if.master       link,       // Two-wire link
  input  wire logic        req,        // Start a transfer, taken when idle
  input  wire logic        req_rd,     // 1 read word, 0 write word
  input  wire logic [7:0]  req_cmd,    // Command byte
  input  wire logic [15:0] req_wdata,  // Write word
  output logic             busy,       // Transfer in progress
  output logic             done,       // One-cycle end pulse
  output logic             nack_err,   // Last transfer saw a refusal
  output logic [15:0]      rd_data     // Last read word
);
  localparam logic [`SMW_QTR_W-1:0] QTR_LAST = `SMW_QTR_W'(`SMW_QTR_CYC - 1);

  smw_pkg::smw_mstate_e st_r;
  smw_pkg::smw_sym_e    sym;
  logic [2:0]  seq_r;
  logic [1:0]  ph_r;
  logic [3:0]  bit_r;
  logic [`SMW_QTR_W-1:0] q_r;
  logic        rd_r;
  logic [7:0]  cmd_r;
  logic [15:0] wdata_r;
  logic [15:0] rx_sh_r;
  logic        ackbit_r;
  logic [7:0]  tx_byte;
  logic        sda_s;
  logic        line_sda;
  logic        line_scl;

  // Only SDA comes back from outside
  smw_sync #(.W(1), .RV(1'b1)) u_sync (.clk(core_clk), .rst(sys_rst), .d(link.sda), .q(sda_s));

  wire tick     = (st_r == smw_pkg::MS_RUN) && (q_r == QTR_LAST);
  wire data_bit = (bit_r != 4'd8);
  wire sym_end  = (ph_r == 2'd3) && ((sym == smw_pkg::SY_START) || (sym == smw_pkg::SY_STOP) || !data_bit);

  // Symbol sequence per transfer kind
  always_comb begin
    sym     = smw_pkg::SY_STOP;
    tx_byte = {`SMW_SLAVE_ADDR, 1'b0};
    unique case ({rd_r, seq_r})
      4'h0, 4'h8: sym = smw_pkg::SY_START;
      4'h1, 4'h9: sym = smw_pkg::SY_TXB;
      4'h2, 4'ha: begin sym = smw_pkg::SY_TXB; tx_byte = cmd_r; end
      4'h3: begin sym = smw_pkg::SY_TXB; tx_byte = wdata_r[7:0]; end
      4'h4: begin sym = smw_pkg::SY_TXB; tx_byte = wdata_r[15:8]; end
      4'hb: sym = smw_pkg::SY_START;
      4'hc: begin sym = smw_pkg::SY_TXB; tx_byte = {`SMW_SLAVE_ADDR, 1'b1}; end
      4'hd, 4'he: sym = smw_pkg::SY_RXB;
      default: sym = smw_pkg::SY_STOP;
    endcase
  end

  // Line levels per quarter: SDA moves with SCL low, except in start and stop
  always_comb begin
    line_scl = (ph_r == 2'd1) || (ph_r == 2'd2);
    line_sda = 1'b1;
    unique case (sym)
      smw_pkg::SY_START: line_sda = (ph_r < 2'd2);
      smw_pkg::SY_STOP: begin
        line_sda = (ph_r >= 2'd2);
        line_scl = (ph_r != 2'd0);
      end
      smw_pkg::SY_TXB: line_sda = data_bit ? tx_byte[3'(4'd7 - bit_r)] : 1'b1;
      smw_pkg::SY_RXB: line_sda = data_bit ? 1'b1 : (seq_r == 3'd6);
    endcase
  end

  // Sequencer
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_r <= smw_pkg::MS_IDLE;
      seq_r <= 3'd0; ph_r <= 2'd0; bit_r <= 4'd0; q_r <= '0;
      rd_r <= 1'b0; cmd_r <= 8'h00; wdata_r <= 16'h0000;
      rx_sh_r <= 16'h0000; ackbit_r <= 1'b0;
      busy <= 1'b0; done <= 1'b0; nack_err <= 1'b0; rd_data <= 16'h0000;
      link.m_scl_oe_n <= 1'b1; link.m_sda_oe_n <= 1'b1;
      link.m_scl_o <= 1'b0; link.m_sda_o <= 1'b0;
    end else begin
      done <= 1'b0;
      q_r  <= tick ? '0 : q_r + `SMW_QTR_W'(1);
      link.m_scl_oe_n <= (st_r == smw_pkg::MS_RUN) ? line_scl : 1'b1;
      link.m_sda_oe_n <= (st_r == smw_pkg::MS_RUN) ? line_sda : 1'b1;
      if (st_r == smw_pkg::MS_IDLE) begin
        q_r <= '0;
        if (req) begin
          st_r <= smw_pkg::MS_RUN; busy <= 1'b1; nack_err <= 1'b0;
          rd_r <= req_rd; cmd_r <= req_cmd; wdata_r <= req_wdata;
          seq_r <= 3'd0; ph_r <= 2'd0; bit_r <= 4'd0;
        end
      end else if (tick) begin
        ph_r <= ph_r + 2'd1;
        // Sample at the end of the second high quarter
        if (ph_r == 2'd2 && sym == smw_pkg::SY_RXB && data_bit) rx_sh_r <= {rx_sh_r[14:0], sda_s};
        if (ph_r == 2'd2 && sym == smw_pkg::SY_TXB && !data_bit) ackbit_r <= sda_s;
        if (ph_r == 2'd3 && !sym_end) bit_r <= bit_r + 4'd1;
        if (sym_end) begin
          bit_r <= 4'd0;
          if (sym == smw_pkg::SY_STOP) begin
            st_r <= smw_pkg::MS_IDLE; busy <= 1'b0; done <= 1'b1;
            if (rd_r && !nack_err) rd_data <= {rx_sh_r[7:0], rx_sh_r[15:8]};
          end else if (sym == smw_pkg::SY_TXB && ackbit_r) begin
            nack_err <= 1'b1;
            seq_r <= rd_r ? 3'd7 : 3'd5;
          end else begin
            seq_r <= seq_r + 3'd1;
          end
        end
      end
    end
  end
endmodule

`default_nettype wire

// File: logic/smw_pkg.sv
/*
  Types shared by the SMBus word target and master.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package smw_pkg;

  // Target states, Gray along idle-rx-ack-tx-master ack
  typedef enum logic [2:0] {
    TS_IDLE = 3'h0,
    TS_RX   = 3'h1,
    TS_ACK  = 3'h3,
    TS_TX   = 3'h2,
    TS_MACK = 3'h6
  } smw_tstate_e;

  // Master line symbols
  typedef enum logic [1:0] {
    SY_START = 2'h0,
    SY_TXB   = 2'h1,
    SY_RXB   = 2'h3,
    SY_STOP  = 2'h2
  } smw_sym_e;

  typedef enum logic {
    MS_IDLE = 1'b0,
    MS_RUN  = 1'b1
  } smw_mstate_e;

endpackage

`default_nettype wire

// File: logic/smw_sync.sv
/*
  Two-flop synchroniser for a group of asynchronous levels.
  Assumes each bit is an independent level; no bus coherence is given.
*/
`timescale 1ns/1ps
`default_nettype none

module smw_sync #(
  parameter int           W  = 1,
  parameter logic [W-1:0] RV = '1
) (
  input  wire logic         clk,  // Sampling clock
  input  wire logic         rst,  // Synchronous reset
  input  wire logic [W-1:0] d,    // Asynchronous levels
  output logic      [W-1:0] q     // Synchronised levels
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= RV;
      q      <= RV;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

`default_nettype wire

// File: logic/smw_target.sv
/*
  SMBus word target end: detects start and stop, matches its address,
  takes word writes and answers word reads, two identity registers.
  Assumes SCL and SDA arrive unsynchronised and change no faster than a
  few core_clk periods apart; read data comes from same-clock user logic.
*/
`timescale 1ns/1ps
`default_nettype none
`include "smw_map.svh"

// Contract
// - Only word write and word read accepted
// - Answer address 0001001 only, ignore others
// - Target only; never drives clock or starts
// - Read-only identity words at FF and FE
// - Stay idle until supply above lockout
// - Start: SDA falls, SCL high; restart tracking
// - Stop: SDA rises, SCL high; go idle
// - Driver changes SDA only while SCL low
// - Bytes MSB first, sampled on SCL rise
// - Nine clocks per byte, receiver acknowledges
// - Write: address, command, low, high, stop
// - Acknowledge address, command, write data low and high
// - Read: command, restart, address read, low first
// - Master acks low byte, nacks high byte
module smw_target #(
  parameter logic [15:0] PART_ID = `SMW_PART_ID  // Arbitrary part identity
) (
  input  wire logic        core_clk,  // 250 MHz clock
  input  wire logic        sys_rst,   // Synchronous reset, high
  smw_link_if.target       link,      // Two-wire link
  input  wire logic        pwr_ok,    // Supply above lockout, asynchronous
  input  wire logic [15:0] rd_data,   // Word for command on cmd
  output logic [7:0]       cmd,       // Last command byte
  output logic             wr_stb,    // One-cycle write pulse
  output logic [15:0]      wr_data,   // Written word
  output logic             busy       // Addressed or receiving
);
  // ****************************************************************
  // Line sampling and bus events
  // ****************************************************************
  logic [2:0] syn;
  logic       scl_d_r;
  logic       sda_d_r;

  smw_sync #(.W(3), .RV(3'b011)) u_sync (
    .clk (core_clk),
    .rst (sys_rst),
    .d   ({pwr_ok, link.sda, link.scl}),
    .q   (syn)
  );

  wire scl_s     = syn[0];
  wire sda_s     = syn[1];
  wire pwr_s     = syn[2];
  // Edges seen on synchronised copies only
  wire scl_rise  = scl_s & ~scl_d_r;
  wire scl_fall  = ~scl_s & scl_d_r;
  wire bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire bus_stop  = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // ****************************************************************
  // Byte tracking state
  // ****************************************************************
  smw_pkg::smw_tstate_e state_r;
  logic [3:0]  bit_r;
  logic [2:0]  idx_r;
  logic [7:0]  rx_sh_r;
  logic [7:0]  lo_r;
  logic [7:0]  tx_sh_r;
  logic [15:0] rd_word_r;
  logic        rw_r;
  logic        have_cmd_r;
  logic        ack_ok_r;
  logic        tx_hi_r;
  logic        mack_ok_r;
  logic        sda_oe_n_r;

  // Byte decode
  wire [7:0]  rx_nxt   = {rx_sh_r[6:0], sda_s};
  wire        addr_hit = (rx_nxt[7:1] == `SMW_SLAVE_ADDR);
  // A read needs a command first; a fifth byte is refused
  wire        byte_ok  = (idx_r == 3'd0) ? (addr_hit & (~rx_nxt[0] | have_cmd_r))
                                         : (idx_r < 3'd4);
  wire        is_id    = (cmd == `SMW_CMD_MAKER) || (cmd == `SMW_CMD_PART);
  wire [15:0] rd_sel   = (cmd == `SMW_CMD_MAKER) ? `SMW_MAKER_ID :
                         (cmd == `SMW_CMD_PART)  ? PART_ID : rd_data;

  // Only SDA is ever driven, and only low
  assign link.t_sda_o    = 1'b0;
  assign link.t_sda_oe_n = sda_oe_n_r;

  // ****************************************************************
  // Protocol engine
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_r    <= smw_pkg::TS_IDLE;
      bit_r      <= 4'd0;
      idx_r      <= 3'd0;
      rx_sh_r    <= 8'h00;
      lo_r       <= 8'h00;
      tx_sh_r    <= 8'hff;
      rd_word_r  <= 16'h0000;
      rw_r       <= 1'b0;
      have_cmd_r <= 1'b0;
      ack_ok_r   <= 1'b0;
      tx_hi_r    <= 1'b0;
      mack_ok_r  <= 1'b0;
      sda_oe_n_r <= 1'b1;
      scl_d_r    <= 1'b1;
      sda_d_r    <= 1'b1;
      cmd        <= 8'h00;
      wr_stb     <= 1'b0;
      wr_data    <= 16'h0000;
      busy       <= 1'b0;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      wr_stb  <= 1'b0;
      busy    <= (state_r != smw_pkg::TS_IDLE);
      if (!pwr_s || bus_stop) begin
        // Bus free, or supply too low to take part
        state_r    <= smw_pkg::TS_IDLE;
        sda_oe_n_r <= 1'b1;
        have_cmd_r <= 1'b0;
      end else if (bus_start) begin
        // Repeated start keeps the command already taken
        state_r    <= smw_pkg::TS_RX;
        bit_r      <= 4'd0;
        idx_r      <= 3'd0;
        rw_r       <= 1'b0;
        sda_oe_n_r <= 1'b1;
      end else begin
        unique case (state_r)
          smw_pkg::TS_IDLE: begin
            sda_oe_n_r <= 1'b1;
          end
          smw_pkg::TS_RX: begin
            if (scl_rise && bit_r != 4'd8) begin
              rx_sh_r <= rx_nxt;
              bit_r   <= bit_r + 4'd1;
              if (bit_r == 4'd7) begin
                ack_ok_r <= byte_ok;
                unique case (idx_r)
                  3'd0: rw_r <= rx_nxt[0];
                  3'd1: begin
                    cmd        <= rx_nxt;
                    have_cmd_r <= 1'b1;
                  end
                  3'd2: lo_r <= rx_nxt;
                  3'd3: begin
                    // Identity words ignore writes
                    wr_stb  <= ~is_id;
                    wr_data <= {rx_nxt, lo_r};
                  end
                  default: ;
                endcase
              end
            end else if (scl_fall && bit_r == 4'd8) begin
              // Ninth clock: ack now or drop off the bus
              state_r    <= ack_ok_r ? smw_pkg::TS_ACK : smw_pkg::TS_IDLE;
              sda_oe_n_r <= ~ack_ok_r;
            end
          end
          smw_pkg::TS_ACK: begin
            if (scl_fall) begin
              bit_r <= 4'd0;
              idx_r <= idx_r + 3'd1;
              if (rw_r) begin
                // Word latched once so both bytes belong together
                state_r    <= smw_pkg::TS_TX;
                rd_word_r  <= rd_sel;
                tx_sh_r    <= rd_sel[7:0];
                tx_hi_r    <= 1'b0;
                sda_oe_n_r <= rd_sel[7];
              end else begin
                state_r    <= smw_pkg::TS_RX;
                sda_oe_n_r <= 1'b1;
              end
            end
          end
          smw_pkg::TS_TX: begin
            if (scl_rise) begin
              bit_r <= bit_r + 4'd1;
            end else if (scl_fall) begin
              if (bit_r == 4'd8) begin
                state_r    <= smw_pkg::TS_MACK;
                bit_r      <= 4'd0;
                sda_oe_n_r <= 1'b1;
              end else begin
                tx_sh_r    <= {tx_sh_r[6:0], 1'b1};
                sda_oe_n_r <= tx_sh_r[6];
              end
            end
          end
          smw_pkg::TS_MACK: begin
            if (scl_rise) begin
              mack_ok_r <= ~sda_s & ~tx_hi_r;
              bit_r     <= 4'd1;
            end else if (scl_fall && bit_r == 4'd1) begin
              bit_r <= 4'd0;
              if (mack_ok_r) begin
                state_r    <= smw_pkg::TS_TX;
                tx_hi_r    <= 1'b1;
                tx_sh_r    <= rd_word_r[15:8];
                sda_oe_n_r <= rd_word_r[15];
              end else begin
                // Released so the master can stop
                state_r    <= smw_pkg::TS_IDLE;
                sda_oe_n_r <= 1'b1;
              end
            end
          end
          default: begin
            state_r    <= smw_pkg::TS_IDLE;
            sda_oe_n_r <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule

`default_nettype wire

// File: sim/smbus_word_slave_port_tb.sv
/*
  Bench of the word master and target joined by one link, plus a second
  target driven bit by bit. Assumes the design files compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "smw_map.svh"

module smbus_word_slave_port_tb;
  localparam logic [15:0] PART_VAL = 16'h3c96;  // Arbitrary part identity
  logic        core_clk = 1'b0;
  logic        sys_rst, pwr_ok, pwr_ok_b, req, req_rd, bscl_oe_n, bsda_oe_n;
  logic [7:0]  req_cmd;
  logic [15:0] req_wdata;
  logic        m_busy, m_done, m_nack, t_stb, t_busy, tb_stb, tb_busy;
  logic [15:0] m_rdata, t_wdata, t_rdata, tb_wdata;
  logic [7:0]  t_cmd, tb_cmd, mshift;
  logic [15:0] mem [256];
  logic [8:0]  mon_q [$];
  logic        mscl_q = 1'b1;
  logic        msda_q = 1'b1;
  int          mbits, stb_cnt, mismatches, cmp_count;

  always #2 core_clk = ~core_clk;

  // ****************************************************************
  // Links, ends and user side
  // ****************************************************************
  smw_link_if link();
  smw_link_if link_b();
  assign link_b.m_scl_o    = 1'b0;
  assign link_b.m_sda_o    = 1'b0;
  assign link_b.m_scl_oe_n = bscl_oe_n;
  assign link_b.m_sda_oe_n = bsda_oe_n;
  assign t_rdata           = mem[t_cmd];

  smw_master u_smw_master (.core_clk(core_clk), .sys_rst(sys_rst), .link(link.master), .req(req),
    .req_rd(req_rd), .req_cmd(req_cmd), .req_wdata(req_wdata), .busy(m_busy), .done(m_done),
    .nack_err(m_nack), .rd_data(m_rdata));
  smw_target #(.PART_ID(PART_VAL)) u_smw_target (.core_clk(core_clk), .sys_rst(sys_rst),
    .link(link.target), .pwr_ok(pwr_ok), .rd_data(t_rdata), .cmd(t_cmd), .wr_stb(t_stb),
    .wr_data(t_wdata), .busy(t_busy));
  smw_target u_smw_target_b (.core_clk(core_clk), .sys_rst(sys_rst), .link(link_b.target),
    .pwr_ok(pwr_ok_b), .rd_data(16'h0000), .cmd(tb_cmd), .wr_stb(tb_stb), .wr_data(tb_wdata),
    .busy(tb_busy));
  smw_link_properties u_smw_link_properties (.core_clk(core_clk), .sys_rst(sys_rst),
    .m_scl_o(link.m_scl_o), .m_scl_oe_n(link.m_scl_oe_n), .m_sda_o(link.m_sda_o),
    .m_sda_oe_n(link.m_sda_oe_n), .t_sda_o(link.t_sda_o), .t_sda_oe_n(link.t_sda_oe_n),
    .scl(link.scl), .sda(link.sda));

  // Register file behind the target; counts write pulses
  always @(posedge core_clk) begin
    if (t_stb === 1'b1) begin
      mem[t_cmd] <= t_wdata;
      stb_cnt    <= stb_cnt + 1;
    end
  end

  // Wire monitor: nine sampled bits per item, a start restarts it
  always @(posedge core_clk) begin
    if (link.scl && mscl_q && msda_q && !link.sda) begin
      mbits = 0;
    end else if (link.scl && !mscl_q) begin
      // Ninth rise carries the acknowledge; the byte is already shifted in
      if (mbits == 8) begin
        mon_q.push_back({mshift, link.sda});
        mbits = 0;
      end else begin
        mshift = {mshift[6:0], link.sda};
        mbits++;
      end
    end
    mscl_q = link.scl;
    msda_q = link.sda;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Request held until busy shows it was taken
  task automatic xfer(input logic rd, input logic [7:0] c, input logic [15:0] w);
    int n;
    mon_q.delete();
    req       = 1'b1;
    req_rd    = rd;
    req_cmd   = c;
    req_wdata = w;
    n         = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (m_busy !== 1'b1 && n < 20);
    req = 1'b0;
    while (m_done !== 1'b1 && n < 20000) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 20000) begin
      mismatches++;
    end
  endtask

  task automatic expect_wire(input logic rd, input logic [7:0] c, input logic [15:0] d);
    logic [8:0] e [$];
    e = '{{`SMW_SLAVE_ADDR, 2'b00}, {c, 1'b0}};
    if (rd) begin
      e.push_back({`SMW_SLAVE_ADDR, 2'b10});
    end
    e.push_back({d[7:0], 1'b0});
    e.push_back({d[15:8], rd});
    chk(16'(mon_q.size()), 16'(e.size()));
    foreach (e[i]) chk({7'h0, mon_q[i]}, {7'h0, e[i]});
  endtask

  task automatic bb_wait(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // One bit cell of 12 cycles, 48 ns; SDA moves only with SCL low
  task automatic bb_bit(input logic v, output logic s);
    bsda_oe_n = v;
    bb_wait(3);
    bscl_oe_n = 1'b1;
    bb_wait(3);
    s = link_b.sda;
    bb_wait(3);
    bscl_oe_n = 1'b0;
    bb_wait(3);
  endtask

  task automatic bb_probe(input logic [7:0] b, output logic ack);
    logic s;
    bb_wait(6);
    bsda_oe_n = 1'b0;
    bb_wait(6);
    bscl_oe_n = 1'b0;
    bb_wait(3);
    for (int i = 7; i >= 0; i--) bb_bit(b[i], s);
    bb_bit(1'b1, ack);
    bsda_oe_n = 1'b0;
    bb_wait(3);
    bscl_oe_n = 1'b1;
    bb_wait(6);
    bsda_oe_n = 1'b1;
    bb_wait(6);
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (80000) @(posedge core_clk);
    mismatches++;
    finish_test();
  end

  initial begin
    int          n0;
    logic        a;
    logic [7:0]  wcmd [3] = '{8'h14, 8'h00, 8'h3f};
    logic [15:0] wdat [3] = '{16'ha53c, 16'hffff, 16'h8001};
    logic [7:0]  pb [4]   = '{{7'h0a, 1'b0}, {7'h48, 1'b0}, {`SMW_SLAVE_ADDR, 1'b1}, {`SMW_SLAVE_ADDR, 1'b0}};
    logic        pa [4]   = '{1'b1, 1'b1, 1'b1, 1'b0};
    {sys_rst, pwr_ok, pwr_ok_b, req, req_rd, bscl_oe_n, bsda_oe_n} = 7'h43;
    req_cmd   = 8'h00;
    req_wdata = 16'h0000;
    bb_wait(10);
    sys_rst = 1'b0;
    pwr_ok  = 1'b1;
    bb_wait(4);
    // Word writes then read-backs, issued back to back
    for (int i = 0; i < 3; i++) begin
      n0 = stb_cnt;
      xfer(1'b0, wcmd[i], wdat[i]);
      expect_wire(1'b0, wcmd[i], wdat[i]);
      chk(16'(stb_cnt - n0), 16'h0001);
      chk({8'h00, t_cmd}, {8'h00, wcmd[i]});
      chk(t_wdata, wdat[i]);
      xfer(1'b1, wcmd[i], 16'h0000);
      expect_wire(1'b1, wcmd[i], wdat[i]);
      chk(m_rdata, wdat[i]);
      chk({15'h0, m_nack}, 16'h0000);
    end
    // Identity words; a write to one is acked but changes nothing
    xfer(1'b1, `SMW_CMD_PART, 16'h0000);
    chk(m_rdata, PART_VAL);
    n0 = stb_cnt;
    xfer(1'b0, `SMW_CMD_MAKER, 16'h1234);
    chk({15'h0, m_nack}, 16'h0000);
    chk(16'(stb_cnt - n0), 16'h0000);
    xfer(1'b1, `SMW_CMD_MAKER, 16'h0000);
    chk(m_rdata, `SMW_MAKER_ID);
    chk({15'h0, t_busy}, 16'h0000);
    // Second target: supply low, then refused and accepted addresses
    bb_probe({`SMW_SLAVE_ADDR, 1'b0}, a);
    chk({15'h0, a}, 16'h0001);
    pwr_ok_b = 1'b1;
    bb_wait(4);
    for (int k = 0; k < 4; k++) begin
      bb_probe(pb[k], a);
      chk({15'h0, a}, {15'h0, pa[k]});
      chk({15'h0, tb_busy}, 16'h0000);
    end
    finish_test();
  end
endmodule

`default_nettype wire

// File: sim/smw_link_properties.sv
/*
  Checker of the two-wire link between the word master and target.
  Assumes the resolved lines of one link instance, one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module smw_link_properties (
  input wire logic core_clk,    // Clock
  input wire logic sys_rst,     // Reset, high
  input wire logic m_scl_o,     // Master SCL out
  input wire logic m_scl_oe_n,  // Master SCL enable
  input wire logic m_sda_o,     // Master SDA out
  input wire logic m_sda_oe_n,  // Master SDA enable
  input wire logic t_sda_o,     // Target SDA out
  input wire logic t_sda_oe_n,  // Target SDA enable
  input wire logic scl,         // SCL level
  input wire logic sda          // SDA level
);
  // ****************************************************************
  // Bit tracking
  // ****************************************************************
  logic       scl_q_r;
  logic       sda_q_r;
  logic [3:0] bit_r;
  logic [2:0] byt_r;
  logic       rd_r;
  logic       bus_r;
  wire        start_w = scl & scl_q_r & sda_q_r & ~sda;
  wire        stop_w  = scl & scl_q_r & ~sda_q_r & sda;
  wire        rise_w  = scl & ~scl_q_r;
  wire        ack_w   = rise_w & (bit_r == 4'h8);

  // Start clears counts; direction taken from the address byte
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      bit_r   <= 4'h0;
      byt_r   <= 3'h0;
      rd_r    <= 1'b0;
      bus_r   <= 1'b0;
    end else begin
      scl_q_r <= scl;
      sda_q_r <= sda;
      if (start_w) begin
        bit_r <= 4'h0;
        byt_r <= 3'h0;
        rd_r  <= 1'b0;
        bus_r <= 1'b1;
      end else if (rise_w) begin
        bit_r <= (bit_r == 4'h9) ? 4'h1 : bit_r + 4'h1;
        byt_r <= (bit_r == 4'h9) ? byt_r + 3'h1 : byt_r;
        rd_r  <= (bit_r == 4'h7 && byt_r == 3'h0) ? sda : rd_r;
      end
      if (stop_w) begin
        bus_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // Only slip-free latency keeps these quiet; SCL high lasts 50 cycles
  target_ack_a: assert property (ack_w && (byt_r == 3'h0 || !rd_r) |-> !t_sda_oe_n)
    else $error("target did not acknowledge");
  ack_stands_a: assert property (ack_w && !t_sda_oe_n |-> (!t_sda_oe_n) [*8])
    else $error("acknowledge dropped while SCL high");
  bits_release_a: assert property (rise_w && !rd_r && bit_r != 4'h8 |-> t_sda_oe_n)
    else $error("target drove SDA during a master bit");
  mack_release_a: assert property (ack_w && rd_r && byt_r != 3'h0 |-> t_sda_oe_n)
    else $error("target drove SDA in the master ack slot");
  master_nack_a: assert property (ack_w && rd_r && byt_r != 3'h0 |-> sda == (byt_r == 3'h2))
    else $error("wrong master ack after read byte");
  sda_change_a: assert property ($changed(t_sda_oe_n) |-> !scl)
    else $error("target changed SDA while SCL high");
  master_sda_a: assert property ($changed(m_sda_oe_n) |-> !scl || start_w || stop_w)
    else $error("master changed SDA while SCL high outside start or stop");
  idle_quiet_a: assert property (!bus_r |-> t_sda_oe_n)
    else $error("target drove SDA on an idle bus");
  start_release_a: assert property (start_w |=> t_sda_oe_n [*8])
    else $error("target held SDA after a start");
  scl_high_a: assert property ($rose(scl) |-> scl [*8])
    else $error("SCL high phase too short");

  cover property (ack_w && !rd_r && byt_r == 3'h3);
  cover property (ack_w && rd_r && byt_r == 3'h2 && sda);
  cover property (start_w && bus_r);
  cover property (stop_w);
endmodule

`default_nettype wire
